// File: rtl/lla_core.sv
// Liquid level alarm sequencer with Avalon-MM register slave
`timescale 1ns/1ps
module lla_core
   import lla_pkg::*;
#(
   parameter int unsigned OSC_DIV = LLA_OSC_DIV_DEF
) (
   // Clock, reset and enable
   input  wire logic                  clock,
   input  wire logic                  rst_b,
   input  wire logic                  clk_en,
   // Sensor and program pins
   input  wire logic                  sense_above,
   input  wire logic                  delay_sel,
   input  wire logic                  pol_duty_sel,
   // Sensor drive and threshold select
   output      logic                  sensor_drive,
   output      logic                  thr_lower_sel,
   // Alarm output
   output      logic                  alarm_out,
   // Avalon-MM slave
   input  wire logic [LLA_ADDR_W-1:0] address,
   input  wire logic                  read,
   input  wire logic                  write,
   input  wire logic [31:0]           writedata,
   output      logic [31:0]           readdata,
   output      logic                  waitrequest,
   // Interrupt
   output      logic                  irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic                 osc_tick;
   logic                 sense_s;
   logic                 delay_sel_s;
   logic                 pol_s;
   logic [2:0]           pins_s;
   logic [LLA_PHASE_W-1:0] phase_q;
   logic [LLA_PHASE_W-1:0] phase_d;
   lla_state_t           st_q;
   lla_state_t           st_d;
   logic [LLA_DLY_W-1:0] dly_cnt_q;
   logic [LLA_DLY_W-1:0] dly_last;
   logic                 sample_en;
   logic                 low_now;
   logic                 dly_done;
   logic [8:0]           on_len;
   logic [0:0]           ctrl_q;
   logic [LLA_IRQ_W-1:0] irq_stat_q;
   logic [LLA_IRQ_W-1:0] irq_mask_q;
   logic [LLA_IRQ_W-1:0] events;
   logic [LLA_IRQ_W-1:0] irq_clr;
   logic                 wr_take;
   logic                 rd_take;
   lla_sel_t             sel;

   if (OSC_DIV < 2) begin : g_chk
      $error("lla_core: OSC_DIV must be at least 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register address decode, shared by read and write paths

   function automatic lla_sel_t reg_decode(input logic [LLA_ADDR_W-1:0] a);
      case (a)
         LLA_OFS_CTRL:     reg_decode = LLA_SEL_CTRL;
         LLA_OFS_STATUS:   reg_decode = LLA_SEL_STATUS;
         LLA_OFS_IRQ_STAT: reg_decode = LLA_SEL_IRQ_STAT;
         LLA_OFS_IRQ_MASK: reg_decode = LLA_SEL_IRQ_MASK;
         LLA_OFS_DLY_CNT:  reg_decode = LLA_SEL_DLY_CNT;
         default:          reg_decode = LLA_SEL_NONE;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator and pin synchronisers

   lla_osc_div #(
      .DIV    (OSC_DIV)
   ) u_osc (
      .clock  (clock),
      .rst_b  (rst_b),
      .clk_en (clk_en),
      .tick   (osc_tick)
   );

   // Program pins are static, so plain level sync is enough
   lla_sync #(
      .WIDTH  (3)
   ) u_sync (
      .clock  (clock),
      .rst_b  (rst_b),
      .clk_en (clk_en),
      .din    ({pol_duty_sel, delay_sel, sense_above}),
      .dout   (pins_s)
   );

   assign sense_s     = pins_s[0];
   assign delay_sel_s = pins_s[1];
   assign pol_s       = pins_s[2];

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator phase: one counter serves drive and alarm waveform

   assign phase_d = phase_q + LLA_PHASE_W'(1);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         phase_q      <= '0;
         sensor_drive <= 1'b1;
      end else if (clk_en && osc_tick) begin
         phase_q      <= phase_d;
         sensor_drive <= ~phase_d[LLA_DRIVE_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sensing with hysteresis, only while the drive is high

   assign sample_en = clk_en && osc_tick && sensor_drive;
   assign low_now   = pol_s ? ~sense_s : sense_s;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         thr_lower_sel <= 1'b0;
      end else if (sample_en) begin
         thr_lower_sel <= sense_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Delay timing and alarm latch

   assign dly_last = delay_sel_s ? LLA_DLY_LONG_LAST : LLA_DLY_SHORT_LAST;
   assign dly_done = clk_en && osc_tick && (st_q == LLA_ST_TIME)
                     && (dly_cnt_q == dly_last)
                     && !(sample_en && !low_now);

   always_comb begin
      st_d = st_q;
      case (st_q)
         LLA_ST_OK: begin
            if (sample_en && low_now) begin
               st_d = LLA_ST_TIME;
            end
         end
         LLA_ST_TIME: begin
            if (sample_en && !low_now) begin
               st_d = LLA_ST_OK;
            end else if (dly_done) begin
               st_d = LLA_ST_ALARM;
            end
         end
         LLA_ST_ALARM: begin
            st_d = LLA_ST_ALARM;
         end
         default: begin
            st_d = LLA_ST_OK;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= LLA_ST_OK;
      end else if (clk_en) begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dly_cnt_q <= '0;
      end else if (clk_en) begin
         if (st_q != LLA_ST_TIME || (sample_en && !low_now)) begin
            dly_cnt_q <= '0;
         end else if (osc_tick && dly_cnt_q != dly_last) begin
            dly_cnt_q <= dly_cnt_q + LLA_DLY_W'(1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alarm waveform

   assign on_len = pol_s ? LLA_ON_HALF : LLA_ON_SHORT;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         alarm_out <= 1'b0;
      end else if (clk_en) begin
         alarm_out <= (st_q == LLA_ST_ALARM) && ctrl_q[LLA_CTRL_OUT_EN]
                      && (phase_q < on_len);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle per request

   assign sel     = reg_decode(address);
   assign rd_take = read && waitrequest;
   assign wr_take = write && !waitrequest;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         waitrequest <= 1'b1;
      end else if (clk_en) begin
         waitrequest <= !((read || write) && waitrequest);
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         readdata <= '0;
      end else if (clk_en && rd_take) begin
         case (sel)
            LLA_SEL_CTRL:     readdata <= {31'h0, ctrl_q};
            LLA_SEL_STATUS:   readdata <= {26'h0, pol_s, delay_sel_s, sensor_drive,
                                           thr_lower_sel, st_q == LLA_ST_TIME,
                                           st_q == LLA_ST_ALARM};
            LLA_SEL_IRQ_STAT: readdata <= {29'h0, irq_stat_q};
            LLA_SEL_IRQ_MASK: readdata <= {29'h0, irq_mask_q};
            LLA_SEL_DLY_CNT:  readdata <= {16'h0, dly_cnt_q};
            default:          readdata <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q     <= LLA_CTRL_RST;
         irq_mask_q <= LLA_IRQ_MASK_RST;
      end else if (clk_en && wr_take) begin
         if (sel == LLA_SEL_CTRL) begin
            ctrl_q <= writedata[0:0];
         end
         if (sel == LLA_SEL_IRQ_MASK) begin
            irq_mask_q <= writedata[LLA_IRQ_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status: sticky, write one to clear, set wins

   assign events[LLA_EV_ALARM]   = (st_q == LLA_ST_TIME) && (st_d == LLA_ST_ALARM);
   assign events[LLA_EV_LOW]     = (st_q == LLA_ST_OK) && (st_d == LLA_ST_TIME);
   assign events[LLA_EV_RESTORE] = (st_q == LLA_ST_TIME) && (st_d == LLA_ST_OK);
   assign irq_clr = (wr_take && sel == LLA_SEL_IRQ_STAT) ? writedata[LLA_IRQ_W-1:0]
                                                         : '0;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         irq_stat_q <= '0;
      end else if (clk_en) begin
         irq_stat_q <= (irq_stat_q & ~irq_clr) | events;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else if (clk_en) begin
         irq <= |(((irq_stat_q & ~irq_clr) | events) & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   drive_edge_a: assert property (@(posedge clock) disable iff (!rst_b)
      $changed(sensor_drive) |->
         $past(clk_en && osc_tick) && ($past(phase_q[3:0]) == 4'hf))
      else $error("sensor drive changed off a 16-tick boundary");

   drive_low_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && osc_tick && !sensor_drive) |=> $stable(thr_lower_sel))
      else $error("threshold changed while drive low");

   hyst_switch_a: assert property (@(posedge clock) disable iff (!rst_b)
      (sample_en && sense_s) |=> thr_lower_sel)
      else $error("lower threshold not selected after exceeding upper");

   low_detect_a: assert property (@(posedge clock) disable iff (!rst_b)
      (sample_en && st_q == LLA_ST_OK && (pol_s ? !sense_s : sense_s))
         |=> st_q == LLA_ST_TIME)
      else $error("low liquid indication did not start delay");

   alarm_delay_a: assert property (@(posedge clock) disable iff (!rst_b)
      (st_q == LLA_ST_ALARM && $past(st_q) == LLA_ST_TIME) |->
         $past(dly_cnt_q) == ($past(delay_sel_s) ? 16'h7fff : 16'h3fff))
      else $error("alarm latched before full delay");

   delay_clear_a: assert property (@(posedge clock) disable iff (!rst_b)
      (sample_en && st_q == LLA_ST_TIME && !low_now) |=>
         (dly_cnt_q == 16'h0000) && (st_q == LLA_ST_OK))
      else $error("adequate sample did not clear delay");

   alarm_latch_a: assert property (@(posedge clock) disable iff (!rst_b)
      st_q == LLA_ST_ALARM |=> st_q == LLA_ST_ALARM)
      else $error("alarm latch released");

   out_duty_a: assert property (@(posedge clock) disable iff (!rst_b)
      (alarm_out && $past(clk_en) && !$past(pol_s)) |->
         ($past(phase_q) < 9'h008) && ($past(st_q) == LLA_ST_ALARM))
      else $error("alarm output outside its active slot");

   alarm_quiet_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && st_q != LLA_ST_ALARM) |=> !alarm_out)
      else $error("alarm output active without latched alarm");

   phase_wrap_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && osc_tick && phase_q == 9'h1ff) |=> (phase_q == 9'h000))
      else $error("alarm phase did not wrap after 512 ticks");

   out_half_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && $past(clk_en) && $past(pol_s) && $past(st_q) == LLA_ST_ALARM
         && $past(ctrl_q[0]) && $past(phase_q) < 9'h100) |-> alarm_out)
      else $error("half duty alarm output missing");

   irq_level_a: assert property (@(posedge clock) disable iff (!rst_b)
      (clk_en && $past(clk_en) && !$past(wr_take)) |->
         irq == |($past(irq_stat_q | events) & $past(irq_mask_q)))
      else $error("interrupt output does not follow status and mask");

endmodule

// File: rtl/lla_osc_div.sv
// Oscillator tick generator dividing the system clock
`timescale 1ns/1ps
module lla_osc_div
   import lla_pkg::*;
#(
   parameter int unsigned DIV = LLA_OSC_DIV_DEF
) (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic clk_en,
   // One-cycle pulse per oscillator period
   output      logic tick
);

   localparam int unsigned CW = (DIV > 2) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] cnt_q;

   if (DIV < 2) begin : g_chk
      $error("lla_osc_div: DIV must be at least 2");
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else if (clk_en) begin
         tick  <= (cnt_q == LAST);
         cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + CW'(1);
      end
   end

endmodule

// File: rtl/lla_pkg.sv
// Package: constants, offsets and types of the liquid level alarm sequencer
package lla_pkg;

   // Clock and reference oscillator
   localparam int unsigned LLA_CLK_HZ         = 100_000_000;
   localparam int unsigned LLA_OSC_HZ         = 1600;
   localparam int unsigned LLA_OSC_DIV_DEF    = LLA_CLK_HZ / LLA_OSC_HZ;

   // Oscillator ratios
   localparam int unsigned LLA_DRIVE_DIV      = 32;
   localparam int unsigned LLA_ALARM_DIV      = 512;
   localparam int unsigned LLA_PHASE_W        = 9;
   localparam int unsigned LLA_DRIVE_BIT      = 4;
   localparam logic [8:0]  LLA_ON_SHORT       = 9'(LLA_ALARM_DIV / 64);
   localparam logic [8:0]  LLA_ON_HALF        = 9'(LLA_ALARM_DIV / 2);

   // Alarm delays in milliseconds and in oscillator ticks
   localparam int unsigned LLA_DLY_SHORT_MS   = 10240;
   localparam int unsigned LLA_DLY_LONG_MS    = 20480;
   localparam int unsigned LLA_DLY_W          = 16;
   localparam logic [15:0] LLA_DLY_SHORT_LAST =
      16'(LLA_DLY_SHORT_MS * LLA_OSC_HZ / 1000 - 1);
   localparam logic [15:0] LLA_DLY_LONG_LAST  =
      16'(LLA_DLY_LONG_MS * LLA_OSC_HZ / 1000 - 1);

   // Register byte offsets
   localparam int unsigned LLA_ADDR_W         = 5;
   localparam logic [4:0]  LLA_OFS_CTRL       = 5'h00;
   localparam logic [4:0]  LLA_OFS_STATUS     = 5'h04;
   localparam logic [4:0]  LLA_OFS_IRQ_STAT   = 5'h08;
   localparam logic [4:0]  LLA_OFS_IRQ_MASK   = 5'h0c;
   localparam logic [4:0]  LLA_OFS_DLY_CNT    = 5'h10;

   // Field positions and reset values
   localparam int unsigned LLA_CTRL_OUT_EN    = 0;
   localparam int unsigned LLA_IRQ_W          = 3;
   localparam int unsigned LLA_EV_ALARM       = 0;
   localparam int unsigned LLA_EV_LOW         = 1;
   localparam int unsigned LLA_EV_RESTORE     = 2;
   localparam logic [0:0]  LLA_CTRL_RST       = 1'h1;
   localparam logic [2:0]  LLA_IRQ_MASK_RST   = 3'h0;

   // Register select
   typedef enum logic [2:0] {
      LLA_SEL_NONE, LLA_SEL_CTRL, LLA_SEL_STATUS,
      LLA_SEL_IRQ_STAT, LLA_SEL_IRQ_MASK, LLA_SEL_DLY_CNT
   } lla_sel_t;

   // Sequencer states, Gray coded along the usual path
   typedef enum logic [1:0] {
      LLA_ST_OK    = 2'b00,
      LLA_ST_TIME  = 2'b01,
      LLA_ST_ALARM = 2'b11
   } lla_state_t;

endpackage

// File: rtl/lla_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module lla_sync
   import lla_pkg::*;
#(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clock,
   input  wire logic             rst_b,
   input  wire logic             clk_en,
   // Data
   input  wire logic [WIDTH-1:0] din,
   output      logic [WIDTH-1:0] dout
);

   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1) begin : g_chk
      $error("lla_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         dout   <= '0;
      end else if (clk_en) begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end

endmodule

// File: verif/lla_core_tb_top.sv
// Self-checking testbench of the liquid level alarm sequencer core
`timescale 1ns/1ps
module lla_core_tb_top
   import lla_pkg::*;
;
   localparam int unsigned DIV = 4;
   localparam int unsigned PER = 32 * DIV;

   logic                  clock;
   logic                  rst_b;
   logic                  clk_en;
   logic                  delay_sel;
   logic                  pol_duty_sel;
   logic                  read;
   logic                  write;
   logic [LLA_ADDR_W-1:0] address;
   logic [31:0]           writedata;
   logic [7:0]            level_pct;
   logic                  sense_above;
   logic                  sensor_drive;
   logic                  thr_lower_sel;
   logic                  alarm_out;
   logic [31:0]           readdata;
   logic                  waitrequest;
   logic                  irq;
   logic [31:0]           rv;
   int                    fail_count;
   int                    n_tests;
   int                    hi;
   int                    per;
   longint                cyc;
   longint                t0;

   lla_core #(.OSC_DIV(DIV)) i_lla_core (
      .clock(clock), .rst_b(rst_b), .clk_en(clk_en), .sense_above(sense_above),
      .delay_sel(delay_sel), .pol_duty_sel(pol_duty_sel), .sensor_drive(sensor_drive),
      .thr_lower_sel(thr_lower_sel), .alarm_out(alarm_out), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq)
   );

   lla_sensor_model i_lla_sensor_model (
      .sensor_drive(sensor_drive), .thr_lower_sel(thr_lower_sel),
      .level_pct(level_pct), .sense_above(sense_above)
   );

   always #5 clock = ~clock;
   always @(posedge clock) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask

   task automatic give_up(input string nm);
      fail_count++;
      $display("unexpected %s: expected answer, seen timeout", nm);
      complete_run();
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return sensor_drive;
         1: return alarm_out;
         2: return thr_lower_sel;
         default: return irq;
      endcase
   endfunction

   // Bounded wait for a level, sampled on the falling edge where outputs are settled
   task automatic wait_sig(input int s, input logic v, input int bound);
      int n;
      n = 0;
      do begin
         @(negedge clock);
         n++;
         if (n > bound) begin
            give_up("signal wait");
         end
      end while (pick(s) !== v);
   endtask

   task automatic bus(input logic wr, input logic [LLA_ADDR_W-1:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
      int n;
      @(posedge clock);
      address   <= a;
      writedata <= wd;
      write     <= wr;
      read      <= !wr;
      n = 0;
      do begin
         @(negedge clock);
         n++;
         if (n > 20) begin
            give_up("bus answer");
         end
      end while (waitrequest !== 1'b0);
      @(posedge clock);
      d = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [LLA_ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] dummy;
      bus(1'b1, a, d, dummy);
   endtask

   task automatic rd(input logic [LLA_ADDR_W-1:0] a);
      bus(1'b0, a, 32'h0, rv);
   endtask

   // High time and period of one full cycle of a wave, in clocks
   task automatic measure(input int s);
      wait_sig(s, 1'b0, 1200 * DIV);
      wait_sig(s, 1'b1, 1200 * DIV);
      hi = 0;
      while (pick(s) === 1'b1 && hi < 1200 * DIV) begin
         @(negedge clock);
         hi++;
      end
      per = hi;
      while (pick(s) === 1'b0 && per < 1200 * DIV) begin
         @(negedge clock);
         per++;
      end
      @(posedge clock);
   endtask

   task automatic do_reset(input logic d, input logic p);
      @(posedge clock);
      rst_b        <= 1'b0;
      delay_sel    <= d;
      pol_duty_sel <= p;
      repeat (4) @(posedge clock);
      rst_b <= 1'b1;
      @(negedge clock);
      check("drive after reset", 32'(sensor_drive), 32'h1);
      check("alarm after reset", 32'(alarm_out), 32'h0);
      check("threshold after reset", 32'(thr_lower_sel), 32'h0);
      check("irq after reset", 32'(irq), 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic sc_reset_regs();
      do_reset(1'b0, 1'b0);
      rd(LLA_OFS_CTRL);
      check("ctrl reset", rv, 32'h1);
      rd(LLA_OFS_IRQ_MASK);
      check("mask reset", rv, 32'h0);
      wr(5'h14, 32'hffff_ffff);
      rd(5'h14);
      check("unmapped read", rv, 32'h0);
      wr(LLA_OFS_IRQ_MASK, 32'h1);
      measure(0);
      check("drive high", 32'(hi), 32'(16 * DIV));
      check("drive period", 32'(per), 32'(PER));
   endtask

   task automatic sc_restart();
      level_pct <= 8'h32;
      wait_sig(2, 1'b1, 2 * PER);
      repeat (3 * PER) @(posedge clock);
      rd(LLA_OFS_STATUS);
      check("timing above", 32'(rv[1]), 32'h1);
      check("low event masked", 32'(irq), 32'h0);
      rd(LLA_OFS_IRQ_STAT);
      check("low event", 32'(rv[1]), 32'h1);
      wr(LLA_OFS_IRQ_STAT, 32'h2);
      rd(LLA_OFS_IRQ_STAT);
      check("low event cleared", 32'(rv[1]), 32'h0);
      level_pct <= 8'h1e;
      repeat (2 * PER) @(posedge clock);
      check("hysteresis kept", 32'(thr_lower_sel), 32'h1);
      rd(LLA_OFS_STATUS);
      check("timing kept", 32'(rv[1]), 32'h1);
      level_pct <= 8'h0a;
      wait_sig(2, 1'b0, 2 * PER);
      rd(LLA_OFS_DLY_CNT);
      check("count cleared", rv, 32'h0);
      rd(LLA_OFS_STATUS);
      check("timing stopped", 32'(rv[1]), 32'h0);
   endtask

   task automatic sc_alarm();
      level_pct <= 8'h32;
      wait_sig(2, 1'b1, 2 * PER);
      t0 = cyc;
      wait_sig(3, 1'b1, 16500 * DIV);
      t0 = cyc - t0;
      check("delay window", (t0 >= 16383 * DIV && t0 <= 16387 * DIV) ? 32'h1 : 32'h0,
            32'h1);
      rd(LLA_OFS_STATUS);
      check("alarm latched", 32'(rv[0]), 32'h1);
      measure(1);
      check("alarm high", 32'(hi), 32'(8 * DIV));
      check("alarm period", 32'(per), 32'(512 * DIV));
      level_pct <= 8'h0a;
      repeat (4 * PER) @(posedge clock);
      check("lower released", 32'(thr_lower_sel), 32'h0);
      rd(LLA_OFS_STATUS);
      check("latch held", 32'(rv[0]), 32'h1);
      measure(1);
      check("alarm kept", 32'(hi), 32'(8 * DIV));
      wr(LLA_OFS_CTRL, 32'h0);
      @(posedge clock);
      hi = 0;
      repeat (512 * DIV) begin
         @(negedge clock);
         hi += int'(alarm_out);
      end
      check("output gated", 32'(hi), 32'h0);
      wr(LLA_OFS_IRQ_STAT, 32'h7);
      repeat (2) @(negedge clock);
      check("irq cleared", 32'(irq), 32'h0);
   endtask

   task automatic sc_pol_high();
      @(posedge clock);
      level_pct <= 8'h32;
      do_reset(1'b1, 1'b1);
      repeat (2) @(posedge clock);
      rd(LLA_OFS_STATUS);
      check("status after reset", rv & 32'h31, 32'h30);
      repeat (4 * PER) @(posedge clock);
      rd(LLA_OFS_STATUS);
      check("no timing above", 32'(rv[1]), 32'h0);
      level_pct <= 8'h1e;
      repeat (2 * PER) @(posedge clock);
      rd(LLA_OFS_STATUS);
      check("hysteresis inverted", 32'(rv[2:1]), 32'h2);
      level_pct <= 8'h0a;
      wait_sig(2, 1'b0, 2 * PER);
      repeat (2 * PER) @(posedge clock);
      rd(LLA_OFS_STATUS);
      check("timing below", 32'(rv[1]), 32'h1);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock        = 1'b0;
      rst_b        = 1'b0;
      clk_en       = 1'b1;
      delay_sel    = 1'b0;
      pol_duty_sel = 1'b0;
      read         = 1'b0;
      write        = 1'b0;
      address      = '0;
      writedata    = 32'h0;
      level_pct    = 8'h0a;
      fail_count   = 0;
      n_tests      = 0;
      cyc          = 0;
      sc_reset_regs();
      sc_restart();
      sc_alarm();
      sc_pol_high();
      complete_run();
   end
endmodule

// File: verif/lla_sensor_model.sv
// Liquid sensor model: received level against the selected threshold
`timescale 1ns/1ps
module lla_sensor_model (
   // Sensor drive and threshold select from the core
   input  wire logic       sensor_drive,
   input  wire logic       thr_lower_sel,
   // Received level in percent of the drive level
   input  wire logic [7:0] level_pct,
   // Comparator result to the core
   output      logic       sense_above
);
   // Input clamps to ground while the drive is low, so the comparator reads below
   always_comb begin
      if (!sensor_drive) begin
         sense_above = 1'b0;
      end else if (thr_lower_sel) begin
         sense_above = (level_pct > 8'h16);
      end else begin
         sense_above = (level_pct > 8'h28);
      end
   end
endmodule
